/* shared/sps_pkg.sv */
// sps_pkg: register map, field positions, reset values and timing for the serial port
package sps_pkg;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [2:0] OFS_CONTROL_ONE       = 3'h0;
	localparam logic [2:0] OFS_CONTROL_TWO       = 3'h1;
	localparam logic [2:0] OFS_CLOCK_RATE_SELECT = 3'h2;
	localparam logic [2:0] OFS_PORT_STATUS       = 3'h3;
	localparam logic [2:0] OFS_DATA_HIGH_BYTE    = 3'h4;
	localparam logic [2:0] OFS_DATA_LOW_BYTE     = 3'h5;

	// ----------------------------------------
	// control_one fields
	// ----------------------------------------
	localparam int BIT_MAIN_IRQ_ENABLE      = 7;
	localparam int BIT_SYSTEM_ENABLE        = 6;
	localparam int BIT_TX_EMPTY_IRQ_ENABLE  = 5;
	localparam int BIT_MASTER_SELECT        = 4;
	localparam int BIT_CLOCK_POLARITY       = 3;
	localparam int BIT_CLOCK_PHASE          = 2;
	localparam int BIT_SELECT_OUTPUT_ENABLE = 1;
	localparam int BIT_LOW_BIT_FIRST        = 0;

	// ----------------------------------------
	// control_two and status fields
	// ----------------------------------------
	localparam int BIT_WORD_WIDTH_SELECT   = 6;
	localparam int BIT_FAULT_DETECT_ENABLE = 4;
	localparam int BIT_BIDIR_OUTPUT_ENABLE = 3;
	localparam int BIT_STOP_IN_WAIT        = 1;
	localparam int BIT_PIN_CONTROL_BIDIR   = 0;
	localparam int BIT_TRANSFER_DONE_FLAG  = 7;
	localparam int BIT_TX_EMPTY_FLAG       = 5;
	localparam int BIT_MODE_FAULT_FLAG     = 4;

	// ----------------------------------------
	// writable masks and reset values
	// ----------------------------------------
	localparam logic [7:0] MASK_CONTROL_TWO = 8'h5B;
	localparam logic [7:0] MASK_RATE        = 8'h77;
	localparam logic [7:0] RST_CONTROL_ONE  = 8'h04;
	localparam logic [7:0] RST_CONTROL_TWO  = 8'h00;
	localparam logic [7:0] RST_RATE         = 8'h00;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int BITS_NARROW   = 8;
	localparam int BITS_WIDE     = 16;

endpackage : sps_pkg

/* core/sps_rate_gen.sv */
// sps_rate_gen: divides the bus clock into serial half-period enable pulses
module sps_rate_gen #(
	parameter int CNT_W = 12
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             resetn,
	// control
	input  wire logic             run,
	input  wire logic             restart,
	input  wire logic [2:0]       preselect,
	input  wire logic [2:0]       exponent,
	// enable pulse, one per half serial period
	output logic                  half_tick
);

	logic [CNT_W-1:0] count_q;
	logic [CNT_W-1:0] half_div;

	// half of (preselect + 1) * 2^(exponent + 1)
	assign half_div = CNT_W'((32'(preselect) + 32'd1) << exponent);

	always_ff @(posedge clk) begin
		if (!resetn || restart) begin
			count_q   <= '0;
			half_tick <= 1'b0;
		end else if (run) begin
			if (count_q >= half_div - CNT_W'(1)) begin
				count_q   <= '0;
				half_tick <= 1'b1;
			end else begin
				count_q   <= count_q + CNT_W'(1);
				half_tick <= 1'b0;
			end
		end else begin
			half_tick <= 1'b0;
		end
	end

endmodule : sps_rate_gen

/* core/sps_port.sv */
// sps_port: master/slave synchronous serial port with register bank
module sps_port (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       resetn,
	// power modes
	input  wire logic       wait_mode,
	input  wire logic       stop_mode,
	// register port
	input  wire logic [2:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	// serial pins
	input  wire logic       sck_i,
	output logic            sck_o,
	output logic            sck_oe,
	input  wire logic       mosi_i,
	output logic            mosi_o,
	output logic            mosi_oe,
	input  wire logic       miso_i,
	output logic            miso_o,
	output logic            miso_oe,
	input  wire logic       ss_n_i,
	output logic            ss_n_o,
	output logic            ss_n_oe,
	// interrupt request
	output logic            irq
);

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_LOAD = 3'b010,
		ST_SHIFT = 3'b100
	} sps_state_t;

	// ----------------------------------------
	// registers and field views
	// ----------------------------------------
	logic [7:0]  ctl1_q, ctl2_q, rate_q;
	logic [15:0] txbuf_q, rxbuf_q, shift_q;
	logic        tx_full_q, done_q, fault_q;
	logic        status_seen_q;
	sps_state_t  state_q;
	logic [4:0]  edge_q;
	logic        sck_q, sample_bit_q;
	logic        sck_s1_q, sck_s2_q, sck_s3_q;
	logic        mosi_s1_q, mosi_s2_q, miso_s1_q, miso_s2_q, ss_s1_q, ss_s2_q;

	logic en, mst, clock_polarity, clock_phase, select_output_enable, lsbf, wide, mfen, bidir, bdoe;
	assign en    = ctl1_q[sps_pkg::BIT_SYSTEM_ENABLE];
	assign mst   = ctl1_q[sps_pkg::BIT_MASTER_SELECT];
	assign clock_polarity  = ctl1_q[sps_pkg::BIT_CLOCK_POLARITY];
	assign clock_phase  = ctl1_q[sps_pkg::BIT_CLOCK_PHASE];
	assign select_output_enable  = ctl1_q[sps_pkg::BIT_SELECT_OUTPUT_ENABLE];
	assign lsbf  = ctl1_q[sps_pkg::BIT_LOW_BIT_FIRST];
	assign wide  = ctl2_q[sps_pkg::BIT_WORD_WIDTH_SELECT];
	assign mfen  = ctl2_q[sps_pkg::BIT_FAULT_DETECT_ENABLE];
	assign bidir = ctl2_q[sps_pkg::BIT_PIN_CONTROL_BIDIR];
	assign bdoe  = ctl2_q[sps_pkg::BIT_BIDIR_OUTPUT_ENABLE];

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		sck_s1_q  <= sck_i;
		sck_s2_q  <= sck_s1_q;
		sck_s3_q  <= sck_s2_q;
		mosi_s1_q <= mosi_i;
		mosi_s2_q <= mosi_s1_q;
		miso_s1_q <= miso_i;
		miso_s2_q <= miso_s1_q;
		ss_s1_q   <= ss_n_i;
		ss_s2_q   <= ss_s1_q;
	end

	// ----------------------------------------
	// write decode and abort causes
	// ----------------------------------------
	logic wr_c1, wr_c2, wr_br, wr_dl, rd_st, rd_dl;
	logic role_chg, cfg_abort, fault_hit, abort;
	logic [7:0] c1_new, c2_new, br_new;
	assign wr_c1  = wr && addr == sps_pkg::OFS_CONTROL_ONE;
	assign wr_c2  = wr && addr == sps_pkg::OFS_CONTROL_TWO;
	assign wr_br  = wr && addr == sps_pkg::OFS_CLOCK_RATE_SELECT;
	assign wr_dl  = wr && addr == sps_pkg::OFS_DATA_LOW_BYTE;
	assign rd_st  = rd && addr == sps_pkg::OFS_PORT_STATUS;
	assign rd_dl  = rd && addr == sps_pkg::OFS_DATA_LOW_BYTE;
	assign c1_new = wdata;
	assign c2_new = wdata & sps_pkg::MASK_CONTROL_TWO;
	assign br_new = wdata & sps_pkg::MASK_RATE;

	assign role_chg = wr_c1 && c1_new[sps_pkg::BIT_MASTER_SELECT] != mst;
	// master config change aborts the transfer
	assign cfg_abort = mst && (
		(wr_c1 && c1_new[3:0] != ctl1_q[3:0]) ||
		(wr_c2 && (c2_new[sps_pkg::BIT_WORD_WIDTH_SELECT] != wide ||
			c2_new[sps_pkg::BIT_FAULT_DETECT_ENABLE] != mfen ||
			c2_new[sps_pkg::BIT_PIN_CONTROL_BIDIR] != bidir ||
			(bidir && c2_new[sps_pkg::BIT_BIDIR_OUTPUT_ENABLE] != bdoe))) ||
		(wr_br && br_new != rate_q));
	// select pin as fault input when master with fault detect and no select output
	assign fault_hit = en && mst && mfen && !select_output_enable && !ss_s2_q;
	assign abort = !en || role_chg || cfg_abort || fault_hit;

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ctl1_q <= sps_pkg::RST_CONTROL_ONE;
			ctl2_q <= sps_pkg::RST_CONTROL_TWO;
			rate_q <= sps_pkg::RST_RATE;
		end else begin
			if (wr_c1) begin
				ctl1_q <= c1_new;
			end else if (fault_hit) begin
				ctl1_q[sps_pkg::BIT_MASTER_SELECT] <= 1'b0;
			end
			if (wr_c2) begin
				ctl2_q <= c2_new;
			end
			if (wr_br) begin
				rate_q <= br_new;
			end
		end
	end

	// ----------------------------------------
	// master clock generation, frozen by power modes
	// ----------------------------------------
	logic halt, run_gen, half_tick;
	// stop mode or wait with stop-in-wait freezes master timing
	assign halt = stop_mode || (wait_mode && ctl2_q[sps_pkg::BIT_STOP_IN_WAIT]);
	assign run_gen = mst && state_q == ST_SHIFT && !halt;

	sps_rate_gen u_rate (
		.clk       (clk),
		.resetn    (resetn),
		.run       (run_gen),
		.restart   (abort || state_q != ST_SHIFT),
		.preselect (rate_q[6:4]),
		.exponent  (rate_q[2:0]),
		.half_tick (half_tick)
	);

	// ----------------------------------------
	// edge events
	// ----------------------------------------
	logic slv_sel, slv_edge, edge_ev, edge_even, in_bit, last_edge;
	logic [4:0] n_edges;
	assign slv_sel  = en && !mst && !ss_s2_q;
	// slave follows the remote clock regardless of power mode
	assign slv_edge = slv_sel && (sck_s2_q != sck_s3_q);
	assign edge_ev  = state_q == ST_SHIFT && (mst ? half_tick : slv_edge);
	assign edge_even = edge_q[0]; // edge_q counts completed edges
	assign n_edges  = wide ? 5'(2 * sps_pkg::BITS_WIDE - 1) : 5'(2 * sps_pkg::BITS_NARROW - 1);
	assign last_edge = edge_q == n_edges;
	// data in pin by role and bidirectional mode
	assign in_bit = mst ? (bidir ? mosi_s2_q : miso_s2_q)
		: (bidir ? miso_s2_q : mosi_s2_q);

	logic out_bit;
	logic [3:0] top_idx;
	assign top_idx = wide ? 4'hF : 4'h7;
	assign out_bit = lsbf ? shift_q[0] : shift_q[top_idx];

	// ----------------------------------------
	// transfer state machine and shifter
	// ----------------------------------------
	logic samp;
	// phase 0 samples on odd edges (edge_q even before the edge)
	assign samp = clock_phase ? edge_even : !edge_even;

	always_ff @(posedge clk) begin
		if (!resetn || abort) begin
			state_q      <= ST_IDLE;
			edge_q       <= '0;
			sck_q        <= 1'b0;
			shift_q      <= '0;
			sample_bit_q <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					edge_q <= '0;
					sck_q  <= 1'b0;
					if (tx_full_q && (mst || slv_sel)) begin
						state_q <= ST_LOAD;
					end
				end
				ST_LOAD: begin
					shift_q <= wide ? txbuf_q : {8'h00, txbuf_q[7:0]};
					state_q <= ST_SHIFT;
				end
				ST_SHIFT: begin
					if (!mst && ss_s2_q) begin
						state_q <= ST_IDLE;
					end else if (edge_ev) begin
						sck_q  <= ~sck_q;
						edge_q <= edge_q + 5'd1;
						if (samp) begin
							sample_bit_q <= in_bit;
						end else if (edge_q != 5'd0) begin
							// shift after the capture half
							if (lsbf) begin
								shift_q <= wide ? {sample_bit_q, shift_q[15:1]}
									: {8'h00, sample_bit_q, shift_q[7:1]};
							end else begin
								shift_q <= wide ? {shift_q[14:0], sample_bit_q}
									: {8'h00, shift_q[6:0], sample_bit_q};
							end
						end
						if (last_edge) begin
							state_q <= ST_IDLE;
						end
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// final bit: live when the last edge samples, held from the edge before otherwise
	logic [15:0] final_word;
	logic        last_in;
	assign last_in = clock_phase ? in_bit : sample_bit_q;
	always_comb begin
		if (lsbf) begin
			final_word = wide ? {last_in, shift_q[15:1]} : {8'h00, last_in, shift_q[7:1]};
		end else begin
			final_word = wide ? {shift_q[14:0], last_in} : {8'h00, shift_q[6:0], last_in};
		end
	end
	logic word_done;
	assign word_done = state_q == ST_SHIFT && edge_ev && last_edge;

	// ----------------------------------------
	// buffers and flags
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!resetn) begin
			txbuf_q   <= '0;
			tx_full_q <= 1'b0;
		end else if (!en) begin
			tx_full_q <= 1'b0;
		end else begin
			if (wr && addr == sps_pkg::OFS_DATA_HIGH_BYTE) begin
				txbuf_q[15:8] <= wdata;
			end
			if (state_q == ST_LOAD) begin
				tx_full_q <= 1'b0;
			end else if (wr_dl) begin
				txbuf_q[7:0] <= wdata;
				tx_full_q    <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			rxbuf_q       <= '0;
			done_q        <= 1'b0;
			fault_q       <= 1'b0;
			status_seen_q <= 1'b0;
		end else if (!en) begin
			done_q        <= 1'b0;
			fault_q       <= 1'b0;
			status_seen_q <= 1'b0;
		end else begin
			if (rd_st) begin
				status_seen_q <= 1'b1;
			end
			// set wins over clear
			if (word_done) begin
				rxbuf_q <= final_word;
				done_q  <= 1'b1;
			end else if (rd_dl && status_seen_q) begin
				done_q        <= 1'b0;
				status_seen_q <= 1'b0;
			end
			if (fault_hit) begin
				fault_q <= 1'b1;
			end else if (wr_c1 && status_seen_q) begin
				fault_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// read port, pins and interrupt
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rdata <= 8'h00;
		end else if (rd) begin
			case (addr)
				sps_pkg::OFS_CONTROL_ONE:       rdata <= ctl1_q;
				sps_pkg::OFS_CONTROL_TWO:       rdata <= ctl2_q;
				sps_pkg::OFS_CLOCK_RATE_SELECT: rdata <= rate_q;
				sps_pkg::OFS_PORT_STATUS: begin
					rdata <= {done_q, 1'b0, en && !tx_full_q, fault_q, 4'h0};
				end
				sps_pkg::OFS_DATA_HIGH_BYTE:    rdata <= wide ? rxbuf_q[15:8] : 8'h00;
				sps_pkg::OFS_DATA_LOW_BYTE:     rdata <= rxbuf_q[7:0];
				default:                        rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	logic act, drive_data;
	assign act = state_q == ST_SHIFT;
	assign drive_data = bidir ? bdoe : 1'b1;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			sck_o   <= 1'b0;
			sck_oe  <= 1'b0;
			mosi_o  <= 1'b0;
			mosi_oe <= 1'b0;
			miso_o  <= 1'b0;
			miso_oe <= 1'b0;
			ss_n_o  <= 1'b1;
			ss_n_oe <= 1'b0;
			irq     <= 1'b0;
		end else begin
			sck_o   <= clock_polarity ^ (act && mst && sck_q);
			sck_oe  <= en && mst;
			mosi_o  <= out_bit;
			mosi_oe <= en && mst && drive_data;
			miso_o  <= out_bit;
			miso_oe <= en && !mst && slv_sel && drive_data;
			ss_n_o  <= !(act || tx_full_q);
			ss_n_oe <= en && mst && mfen && select_output_enable;
			irq     <= (ctl1_q[sps_pkg::BIT_MAIN_IRQ_ENABLE] && (done_q || fault_q)) ||
				(ctl1_q[sps_pkg::BIT_TX_EMPTY_IRQ_ENABLE] && en && !tx_full_q);
		end
	end

endmodule : sps_port

/* tb/sps_port_sva.sv */
// sps_port_sva: port-level assertions for the serial port
module sps_port_sva (
	// clock and reset
	input wire logic       clk,
	input wire logic       resetn,
	// register port
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	// pin enables and interrupt
	input wire logic       sck_oe,
	input wire logic       mosi_oe,
	input wire logic       miso_oe,
	input wire logic       ss_n_oe,
	input wire logic       irq
);
	logic [7:0] ctl1_q;
	logic [7:0] ctl2_q;
	logic       ena, mst, sso, fde, wide;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	// shadow of both control registers; a mode fault only ever clears master
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ctl1_q <= sps_pkg::RST_CONTROL_ONE;
			ctl2_q <= sps_pkg::RST_CONTROL_TWO;
		end else if (wr && addr == sps_pkg::OFS_CONTROL_ONE) begin
			ctl1_q <= wdata;
		end else if (wr && addr == sps_pkg::OFS_CONTROL_TWO) begin
			ctl2_q <= wdata & sps_pkg::MASK_CONTROL_TWO;
		end
	end
	assign ena  = ctl1_q[6];
	assign mst  = ctl1_q[4];
	assign sso  = ctl1_q[1];
	assign fde  = ctl2_q[4];
	assign wide = ctl2_q[6];

	sequence off_s; !ena [*4]; endsequence
	sequence slv_s; !mst [*4]; endsequence
	sequence mst_s; (mst && !fde) [*4]; endsequence
	sequence sel_s; (ena && mst && sso && fde) [*4]; endsequence

	rd_quiet_a: assert property (!rd |=> rdata == 8'h00)
		else $error("rdata set without a read");
	rsvd_read_a: assert property (rd && addr[2:1] == 2'b11 |=> rdata == 8'h00)
		else $error("reserved offset read not zero");
	stat_rsvd_a: assert property (rd && addr == 3'h3 |=> (rdata & 8'h4F) == 8'h00)
		else $error("reserved status bits not zero");
	high_zero_a: assert property (rd && addr == 3'h4 && !wide |=> rdata == 8'h00)
		else $error("high byte not zero in 8-bit width");
	off_quiet_a: assert property (off_s |-> !(sck_oe | mosi_oe | miso_oe | ss_n_oe | irq))
		else $error("disabled port drives a pin or irq");
	slv_pins_a: assert property (slv_s |-> !sck_oe && !mosi_oe && !ss_n_oe)
		else $error("slave drives sck, mosi or select");
	mst_miso_a: assert property (mst_s |-> !miso_oe)
		else $error("master drives miso");
	no_sel_a: assert property (mst_s |-> !ss_n_oe)
		else $error("select pin driven with fault detect off");
	sel_out_a: assert property (sel_s |-> ss_n_oe)
		else $error("select output not driven");
endmodule : sps_port_sva

bind sps_port sps_port_sva chk_u (
	.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
	.rdata(rdata), .sck_oe(sck_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe),
	.ss_n_oe(ss_n_oe), .irq(irq)
);

/* tb/sps_slave_model.sv */
// sps_slave_model: remote serial device answering the port as master
module sps_slave_model (
	// serial wires
	input  wire logic        sck,
	input  wire logic        mosi,
	input  wire logic        sel_n,
	output logic             miso,
	// set-up from the bench
	input  wire logic        clock_phase,
	input  wire logic        load,
	input  wire logic [15:0] tx_word,
	output logic      [15:0] rx_q
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] tx_q;
	int          edge_n;
	logic        sel_prev;

	// select as it stood before this time step, so the closing edge still counts
	always @(sel_n) sel_prev <= sel_n;

	// deselected line shows the inverse of the next bit to send
	assign miso = sel_n ? ~tx_q[15] : tx_q[15];
	always @(posedge load) begin
		edge_n = 0;
		tx_q = tx_word;
		rx_q = 16'h0000;
	end
	// same polarity as the port; sample on odd or even edges by phase
	always @(sck) begin
		if (!load && !sel_prev) begin
			edge_n = edge_n + 1;
			if (edge_n[0] ^ clock_phase) begin
				rx_q = {rx_q[14:0], mosi};
			end else if (edge_n > 1) begin
				tx_q = {tx_q[14:0], 1'b0};
			end
		end
	end
endmodule : sps_slave_model

/* tb/sps_port_tb_top.sv */
// sps_port_tb_top: register-level tests of the serial port with a remote device
module sps_port_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, resetn, wait_mode, stop_mode, wr, rd, irq, load, clock_phase_m, ss_tb;
	logic [2:0]  addr;
	logic [7:0]  wdata, rdata, v;
	logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_n_o, ss_n_oe, miso_m;
	logic [15:0] tx_word, rx, w;
	logic [3:0]  modes [4] = '{4'h0, 4'h3, 4'hD, 4'hE};
	int          num_errors = 0, n_tests = 0, cyc = 0;
	time         t0, t1, tf;
	// sck pulled low, mosi pulled high when released
	wire logic   sck_w = sck_oe ? sck_o : 1'b0;
	wire logic   mosi_w = mosi_oe ? mosi_o : 1'b1;
	wire logic   miso_w = miso_oe ? miso_o : miso_m;
	wire logic   ss_w = ss_n_oe ? ss_n_o : ss_tb;

	sps_port dut_u (
		.clk(clk), .resetn(resetn), .wait_mode(wait_mode), .stop_mode(stop_mode),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe),
		.mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
		.miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe),
		.ss_n_i(ss_w), .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe), .irq(irq)
	);
	sps_slave_model model_u (
		.sck(sck_w), .mosi(mosi_w), .sel_n(ss_w), .miso(miso_m),
		.clock_phase(clock_phase_m), .load(load), .tx_word(tx_word), .rx_q(rx)
	);

	// ----
	// helpers
	// ----
	task automatic results();
		if (num_errors == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : results
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic wreg(input logic [2:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask : wreg
	task automatic rreg(input logic [2:0] a, output logic [7:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask : rreg
	function automatic logic [15:0] rev(input logic [15:0] x, input int n);
		rev = 16'h0000;
		for (int i = 0; i < n; i++) rev[i] = x[n-1-i];
	endfunction : rev
	// m = {wide, polarity, phase, low bit first}; halts mid-word by wait or stop
	task automatic xfer(input logic [3:0] m);
		int          n;
		logic [15:0] d;
		n = m[3] ? 16 : 8;
		d = m[3] ? 16'hA5C3 : 16'h0096;
		wreg(sps_pkg::OFS_CONTROL_TWO, {1'b0, m[3], 6'h12});
		wreg(sps_pkg::OFS_CLOCK_RATE_SELECT, 8'h11);
		wreg(sps_pkg::OFS_CONTROL_ONE, {4'hD, m[2:1], 1'b1, m[0]});
		clock_phase_m <= m[1];
		tx_word <= m[3] ? 16'h3C5A : 16'h6900;
		repeat (4) @(posedge clk);
		chk("idle sck", 16'(sck_w), 16'(m[2]));
		load <= 1'b1;
		@(posedge clk);
		load <= 1'b0;
		if (m[3]) wreg(sps_pkg::OFS_DATA_HIGH_BYTE, d[15:8]);
		wreg(sps_pkg::OFS_DATA_LOW_BYTE, d[7:0]);
		repeat (20) @(posedge clk);
		{stop_mode, wait_mode} <= m[0] ? 2'b10 : 2'b01;
		repeat (3) @(posedge clk);
		v[0] = sck_w;
		tf = t0;
		repeat (40) @(posedge clk);
		chk("frozen sck", 16'(sck_w), 16'(v[0]));
		chk("frozen edges", 16'(t0 - tf), 16'h0000);
		{stop_mode, wait_mode} <= 2'b00;
		v = 8'h00;
		for (int i = 0; i < 400 && !v[7]; i++) rreg(sps_pkg::OFS_PORT_STATUS, v);
		chk("done irq", 16'(irq), 16'h0001);
		// half period is (preselect + 1) * 2 ** exponent bus clocks
		chk("half period", 16'(t0 - t1), 16'(4 * sps_pkg::CLK_PERIOD_NS));
		rreg(sps_pkg::OFS_DATA_LOW_BYTE, v);
		w[7:0] = v;
		rreg(sps_pkg::OFS_DATA_HIGH_BYTE, v);
		w[15:8] = v;
		w = m[0] ? rev(w, n) : w;
		chk("rx word", w, tx_word >> (16 - n));
		chk("tx word", rx, m[0] ? rev(d, n) : d);
		chk("irq cleared", 16'(irq), 16'h0000);
	endtask : xfer

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(sck_w) begin
		t1 = t0;
		t0 = $time;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			results();
		end
	end

	// ----
	// main sequence
	// ----
	initial begin
		{resetn, wait_mode, stop_mode, wr, rd, load, clock_phase_m} = 7'h00;
		{addr, wdata, tx_word} = 27'h0;
		ss_tb = 1'b1;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 8; i++) begin
			rreg(3'(i), v);
			chk("reset value", 16'(v), 16'(i == 0 ? sps_pkg::RST_CONTROL_ONE : 8'h00));
		end
		wreg(sps_pkg::OFS_CONTROL_TWO, 8'hFF);
		wreg(sps_pkg::OFS_CLOCK_RATE_SELECT, 8'hFF);
		wreg(3'h7, 8'hFF);
		rreg(sps_pkg::OFS_CONTROL_TWO, v);
		chk("ctl2 mask", 16'(v), 16'h005B);
		rreg(sps_pkg::OFS_CLOCK_RATE_SELECT, v);
		chk("rate mask", 16'(v), 16'h0077);
		rreg(3'h7, v);
		chk("reserved", 16'(v), 16'h0000);
		for (int i = 0; i < 4; i++) xfer(modes[i]);
		// phase change in mid-word must abort and idle the clock
		wreg(sps_pkg::OFS_DATA_LOW_BYTE, 8'h55);
		repeat (10) @(posedge clk);
		wreg(sps_pkg::OFS_CONTROL_ONE, 8'hDA);
		repeat (200) @(posedge clk);
		rreg(sps_pkg::OFS_PORT_STATUS, v);
		chk("abort done", 16'(v[7]), 16'h0000);
		chk("abort idle", 16'(sck_w), 16'h0001);
		wreg(sps_pkg::OFS_CONTROL_TWO, 8'h10);
		wreg(sps_pkg::OFS_CONTROL_ONE, 8'hD0);
		ss_tb <= 1'b0;
		repeat (6) @(posedge clk);
		chk("fault irq", 16'(irq), 16'h0001);
		rreg(sps_pkg::OFS_PORT_STATUS, v);
		chk("fault flag", 16'(v & 8'h10), 16'h0010);
		rreg(sps_pkg::OFS_CONTROL_ONE, v);
		chk("to slave", 16'(v), 16'h00C0);
		// master with fault detect off must ignore a low select pin
		wreg(sps_pkg::OFS_CONTROL_TWO, 8'h00);
		wreg(sps_pkg::OFS_CONTROL_ONE, 8'hD0);
		repeat (8) @(posedge clk);
		chk("select ignored", 16'(irq), 16'h0000);
		rreg(sps_pkg::OFS_CONTROL_ONE, v);
		chk("still master", 16'(v), 16'h00D0);
		ss_tb <= 1'b1;
		wreg(sps_pkg::OFS_CONTROL_ONE, 8'h00);
		rreg(sps_pkg::OFS_PORT_STATUS, v);
		chk("flags reset", 16'(v), 16'h0000);
		results();
	end
endmodule : sps_port_tb_top
